// >>> logic/pmm_map.sv
// Paged management memory map: host byte accesses onto paged storage.
// Assumes the serial slave and module firmware share this clock.
//
// How it works
// - Host addresses are eight bits, reaching a 256-byte space.
// - 00h-7Fh decode as lower region, 80h-FFh as upper region.
// - Storage is 128-byte pages; one selected page fills the upper region.
// - Lower region is one space, reachable whatever page or bank is selected.
// - A bank select picks which instance of a repeated page appears.
// - Lower region and page 00h always exist.
// - Paged builds also hold pages 01h, 02h and NUM_BANKS banks of 10h-1Fh.
// - Bank n of pages 10h-1Fh serves lanes 8n to 8n+7.
// - Flat build shows unpaged 256 bytes with a fixed upper region.
`timescale 1ns/10ps
`default_nettype none
module pmm_map #(
  parameter int NUM_BANKS = pmm_pkg::DEF_NUM_BANKS, // Banks of pages 10h..1Fh
  parameter bit PAGED = 1'b1,                        // 0 = flat copper build
  localparam int SLOTS = pmm_pkg::SLOT_LANE0 + pmm_pkg::LANE_PAGES * NUM_BANKS,
  localparam int SW = $clog2(SLOTS),
  localparam int PAW = SW + pmm_pkg::OFS_W
) (
  input wire logic clock_i,                     // Management clock, 200 MHz
  input wire logic rst_i,                       // Async reset, active high
  input wire logic ce_i,                        // Clock enable, freezes all
  input wire logic req_valid_i,                 // Host byte access request
  input wire pmm_pkg::pmm_req_type req_i,       // Host access details
  input wire logic loc_we_i,                    // Firmware write request
  input wire logic [PAW-1:0] loc_addr_i,        // Firmware physical address
  input wire logic [pmm_pkg::DATA_W-1:0] loc_data_i, // Firmware write byte
  output logic rsp_valid_o,                     // Host answer pulse
  output pmm_pkg::pmm_rsp_type rsp_o,           // Host answer
  output logic [7:0] page_o,                    // Selected page
  output logic [7:0] bank_o,                    // Selected bank
  output logic [7:0] lane_base_o,               // First lane of selected bank
  output logic loc_ack_o                        // Firmware write taken
);
  import pmm_pkg::*;

  // ------------------------------------------------------------------
  // Page and bank lookup
  // ------------------------------------------------------------------

  // Whether a page/bank pair has storage in this build
  function automatic logic map_hit(input logic [7:0] pg, input logic [7:0] bk);
    logic hit;
    hit = 1'b0;
    if (!PAGED) begin
      hit = 1'b1;
    end else if (pg == PAGE_00) begin
      hit = 1'b1;
    end else if (pg == PAGE_01 || pg == PAGE_02) begin
      hit = 1'b1;
    end else if (pg >= PAGE_LANE_FIRST && pg <= PAGE_LANE_LAST) begin
      hit = (32'(bk) < NUM_BANKS);
    end
    return hit;
  endfunction : map_hit

  // Storage slot for a page/bank pair; only meaningful on a hit
  function automatic logic [15:0] map_slot(input logic [7:0] pg, input logic [7:0] bk);
    logic [15:0] slot;
    slot = 16'(SLOT_P00);
    if (PAGED) begin
      case (pg)
        PAGE_01: begin
          slot = 16'(SLOT_P01);
        end
        PAGE_02: begin
          slot = 16'(SLOT_P02);
        end
        default: begin
          if (pg >= PAGE_LANE_FIRST && pg <= PAGE_LANE_LAST) begin
            // Banks stacked after the fixed pages, one run of 16 per bank
            slot = 16'(SLOT_LANE0) + 16'(LANE_PAGES) * {8'h00, bk}
                   + {8'h00, 8'(pg - PAGE_LANE_FIRST)};
          end
        end
      endcase
    end
    return slot;
  endfunction : map_slot

  // ------------------------------------------------------------------
  // Request decode
  // ------------------------------------------------------------------
  logic [7:0] page;
  logic [7:0] bank;
  logic host_take;
  logic loc_take;
  logic upper;
  logic sel_byte;
  logic page_hit;
  logic [15:0] page_slot;
  logic mem_we;
  logic [PAW-1:0] mem_addr;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] mem_rdata;

  // Address split and selection lookup with the selection held now
  always_comb begin
    host_take = ce_i && req_valid_i;
    loc_take = ce_i && loc_we_i && !req_valid_i; // Host wins the single port
    upper = req_i.addr[UPPER_BIT];
    sel_byte = PAGED && !upper &&
               (req_i.addr == BANK_SEL_ADDR || req_i.addr == PAGE_SEL_ADDR);
    page_hit = map_hit(page, bank);
    page_slot = map_slot(page, bank);
  end

  // Storage port steering; selection bytes live in flops, not storage
  always_comb begin
    mem_we = 1'b0;
    mem_addr = loc_addr_i;
    mem_wdata = loc_data_i;
    if (req_valid_i) begin
      mem_wdata = req_i.wdata;
      if (upper) begin
        mem_addr = {page_slot[SW-1:0], req_i.addr[OFS_W-1:0]};
        // Flat build keeps the upper region fixed for the host
        mem_we = host_take && req_i.write && page_hit && PAGED;
      end else begin
        mem_addr = {SW'(SLOT_LOWER), req_i.addr[OFS_W-1:0]};
        mem_we = host_take && req_i.write && !sel_byte;
      end
    end else begin
      mem_we = loc_take;
    end
  end

  pmm_mem #(
    .AW(PAW),
    .DW(DATA_W)
  ) u_store (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  // ------------------------------------------------------------------
  // Page and bank selection
  // ------------------------------------------------------------------

  // Written through the lower region; any value taken, absence shows as miss
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      page <= PAGE_RESET;
    end else if (host_take && req_i.write && sel_byte && req_i.addr == PAGE_SEL_ADDR) begin
      page <= req_i.wdata;
    end
  end

  // Bank select and the lane group it serves move together
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bank <= BANK_RESET;
      lane_base_o <= BANK_RESET;
    end else if (host_take && req_i.write && sel_byte && req_i.addr == BANK_SEL_ADDR) begin
      bank <= req_i.wdata;
      lane_base_o <= 8'(req_i.wdata << LANE_SHIFT);
    end
  end

  // Mirrors of the selection for the module side
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      page_o <= PAGE_RESET;
      bank_o <= BANK_RESET;
    end else if (ce_i) begin
      page_o <= page;
      bank_o <= bank;
    end
  end

  // ------------------------------------------------------------------
  // Answer pipeline, two edges from request
  // ------------------------------------------------------------------
  logic s1_valid;
  logic s1_write;
  logic s1_miss;
  logic s1_sel;
  logic [DATA_W-1:0] s1_sel_data;

  // Stage beside the storage read register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s1_valid <= 1'b0;
      s1_write <= 1'b0;
      s1_miss <= 1'b0;
      s1_sel <= 1'b0;
      s1_sel_data <= DATA_ZERO;
    end else if (ce_i) begin
      s1_valid <= req_valid_i;
      s1_write <= req_i.write;
      s1_miss <= upper && !page_hit;
      s1_sel <= sel_byte;
      // Read of a select byte returns the selection before any update
      s1_sel_data <= (req_i.addr == PAGE_SEL_ADDR) ? page : bank;
    end
  end

  // Answer register; absent pages read as zero and flag the miss
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_o <= '0;
    end else if (ce_i) begin
      rsp_valid_o <= s1_valid;
      rsp_o.miss <= s1_valid && s1_miss;
      if (!s1_valid || s1_write || s1_miss) begin
        rsp_o.data <= DATA_ZERO;
      end else if (s1_sel) begin
        rsp_o.data <= s1_sel_data;
      end else begin
        rsp_o.data <= mem_rdata;
      end
    end
  end

  // Firmware write acknowledge, lost to a host access in the same cycle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      loc_ack_o <= 1'b0;
    end else if (ce_i) begin
      loc_ack_o <= loc_take;
    end
  end

endmodule : pmm_map
`default_nettype wire

// >>> pkg/pmm_pkg.sv
// Constants and carrier types for the paged management memory map.
// Assumes a single management clock; shared by the map, its checker and the bench models.
`default_nettype none
package pmm_pkg;

  // ------------------------------------------------------------------
  // Host address space
  // ------------------------------------------------------------------
  localparam int ADDR_W = 8;                 // Host byte address width
  localparam int DATA_W = 8;                 // Byte-wide data
  localparam int OFS_W = 7;                  // Offset inside a 128-byte region
  localparam int UPPER_BIT = 7;              // Set for 80h..FFh
  localparam logic [7:0] BANK_SEL_ADDR = 8'h7E; // Bank select byte in lower region
  localparam logic [7:0] PAGE_SEL_ADDR = 8'h7F; // Page select byte in lower region

  // ------------------------------------------------------------------
  // Pages and banks
  // ------------------------------------------------------------------
  localparam logic [7:0] PAGE_00 = 8'h00;
  localparam logic [7:0] PAGE_01 = 8'h01;
  localparam logic [7:0] PAGE_02 = 8'h02;
  localparam logic [7:0] PAGE_LANE_FIRST = 8'h10;
  localparam logic [7:0] PAGE_LANE_LAST = 8'h1F;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam int LANE_PAGES = 16;            // Pages 10h..1Fh per bank
  localparam int LANE_SHIFT = 3;             // Eight lanes per bank
  localparam int DEF_NUM_BANKS = 1;

  // ------------------------------------------------------------------
  // Physical storage slots, 128 bytes each
  // ------------------------------------------------------------------
  localparam int SLOT_LOWER = 0;
  localparam int SLOT_P00 = 1;
  localparam int SLOT_P01 = 2;
  localparam int SLOT_P02 = 3;
  localparam int SLOT_LANE0 = 4;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic write;                 // 1 = write, 0 = read
    logic [ADDR_W-1:0] addr;     // Host byte address
    logic [DATA_W-1:0] wdata;    // Write byte
  } pmm_req_type;

  typedef struct packed {
    logic miss;                  // Upper access to an absent page or bank
    logic [DATA_W-1:0] data;     // Read byte, zero for writes and misses
  } pmm_rsp_type;

endpackage : pmm_pkg
`default_nettype wire

// >>> logic/pmm_mem.sv
// Single-port byte store behind the management map.
// Assumes one clock; read data always come out of a register.
`timescale 1ns/10ps
`default_nettype none
module pmm_mem #(
  parameter int AW = 10,                     // Physical address width
  parameter int DW = 8                       // Word width
) (
  input wire logic clock_i,                  // Management clock
  input wire logic rst_i,                    // Async reset, active high
  input wire logic ce_i,                     // Clock enable
  input wire logic we_i,                     // Write strobe
  input wire logic [AW-1:0] addr_i,          // Physical address
  input wire logic [DW-1:0] wdata_i,         // Write data
  output logic [DW-1:0] rdata_o              // Registered read data
);

  logic [DW-1:0] store [0:(2**AW)-1];

  // Storage has no reset: contents are loaded by module firmware
  always_ff @(posedge clock_i) begin
    if (ce_i && we_i) begin
      store[addr_i] <= wdata_i;
    end
  end

  // Read register, read-before-write on a shared address
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= store[addr_i];
    end
  end

endmodule : pmm_mem
`default_nettype wire

// >>> sim/pmm_map_assertions.sv
// Port checker for the paged management memory map.
// Assumes one clock domain; bound to every pmm_map instance.
`timescale 1ns/10ps
`default_nettype none
module pmm_map_assertions (
  input wire logic clock_i, // Management clock
  input wire logic rst_i, // Async reset
  input wire logic ce_i, // Clock enable
  input wire logic req_valid_i, // Host strobe
  input wire pmm_pkg::pmm_req_type req_i, // Host access
  input wire logic loc_we_i, // Firmware write
  input wire logic rsp_valid_o, // Host answer pulse
  input wire pmm_pkg::pmm_rsp_type rsp_o, // Host answer
  input wire logic [7:0] page_o, // Selected page
  input wire logic [7:0] bank_o, // Selected bank
  input wire logic [7:0] lane_base_o, // First lane
  input wire logic loc_ack_o // Firmware ack
);
  import pmm_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // Host answer timing
  // ----------------------------------------------------------------
  a_rsp_two_cycles: assert property (req_valid_i && ce_i ##1 ce_i ##1 ce_i |-> rsp_valid_o)
    else $error("answer missing two cycles after request");
  a_rsp_has_cause: assert property (rsp_valid_o |-> $past(req_valid_i, 2))
    else $error("answer without request");
  a_write_zero_data: assert property (rsp_valid_o && $past(req_i.write, 2) |-> rsp_o.data == 8'h00)
    else $error("write answer carries data");
  // Lower region never depends on the selection
  a_lower_never_miss: assert property (req_valid_i && ce_i && !req_i.addr[UPPER_BIT] |-> ##2 !rsp_o.miss)
    else $error("lower access reported miss");
  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  // Mirrors trail the live selection by one enabled edge
  a_page_sel_follow: assert property (
    req_valid_i && ce_i && req_i.write && req_i.addr == PAGE_SEL_ADDR ##1 ce_i
    |=> page_o == $past(req_i.wdata, 2))
    else $error("page select not applied");
  a_bank_sel_follow: assert property (
    req_valid_i && ce_i && req_i.write && req_i.addr == BANK_SEL_ADDR ##1 ce_i
    |=> bank_o == $past(req_i.wdata, 2))
    else $error("bank select not applied");
  // Lane base moves with the live bank, so it leads the bank mirror by one edge
  a_lane_base_map: assert property (ce_i |=> {bank_o[4:0], 3'h0} == $past(lane_base_o))
    else $error("lane base not eight per bank");
  // Host has priority over firmware loads
  a_ack_has_cause: assert property (loc_ack_o |-> $past(loc_we_i && !req_valid_i && ce_i))
    else $error("ack without firmware write");
  c_miss: cover property (rsp_valid_o && rsp_o.miss);
  c_page_sel: cover property (req_valid_i && req_i.write && req_i.addr == PAGE_SEL_ADDR);
  c_ack: cover property (loc_ack_o);
endmodule : pmm_map_assertions
bind pmm_map pmm_map_assertions i_pmm_map_assertions (.*);
`default_nettype wire

// >>> sim/pmm_host_model.sv
// Host controller model driving the map's byte access port.
// Assumes its tasks are entered at a falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module pmm_host_model (
  input wire logic clock_i, // Management clock
  output logic req_valid_o, // Access strobe
  output pmm_pkg::pmm_req_type req_o // Access details
);
  import pmm_pkg::*;
  // Idle at time zero
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
  end
  // One eight-bit addressed access, held over its taking edge
  task automatic send(input logic w, input logic [7:0] a, input logic [7:0] d);
    req_valid_o = 1'b1;
    req_o = '{w, a, d};
    @(posedge clock_i);
    @(negedge clock_i);
  endtask : send
  // Details scrambled when idle so no stale request can match
  task automatic idle();
    req_valid_o = 1'b0;
    req_o = ~req_o;
  endtask : idle
endmodule : pmm_host_model
`default_nettype wire

// >>> sim/pmm_map_tb_top.sv
// Self-checking bench for the paged management memory map.
// Assumes two lane banks; inputs change on the falling edge.
`timescale 1ns/10ps
`default_nettype none
module pmm_map_tb_top;
  import pmm_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic loc_we_i = 1'b0;
  logic [12:0] loc_addr_i = '0;
  logic [7:0] loc_data_i = '0;
  logic req_valid_i, rsp_valid_o, loc_ack_o;
  pmm_req_type req_i;
  pmm_rsp_type rsp_o;
  logic [7:0] page_o, bank_o, lane_base_o;
  pmm_rsp_type rq[$];
  int err_count = 0;
  int check_count = 0;
  always #2.5 clock_i = ~clock_i;
  pmm_host_model i_pmm_host_model (.clock_i(clock_i), .req_valid_o(req_valid_i), .req_o(req_i));
  pmm_map #(.NUM_BANKS(2)) i_pmm_map (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .loc_we_i(loc_we_i), .loc_addr_i(loc_addr_i),
    .loc_data_i(loc_data_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .page_o(page_o),
    .bank_o(bank_o), .lane_base_o(lane_base_o), .loc_ack_o(loc_ack_o));
  // Answers collected where settled
  always @(negedge clock_i) if (rsp_valid_o === 1'b1) rq.push_back(rsp_o);
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait for the next answer
  task automatic expect_rsp(input logic m, input logic [7:0] d);
    int n = 0;
    while (rq.size() == 0 && n < 8) begin
      @(negedge clock_i);
      n++;
    end
    if (rq.size() == 0) begin
      err_count++;
      print_verdict();
    end
    chk({7'h00, rq.pop_front()}, {7'h00, m, d});
  endtask : expect_rsp
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic m,
                     input logic [7:0] e);
    i_pmm_host_model.send(w, a, d);
    i_pmm_host_model.idle();
    expect_rsp(m, e);
  endtask : acc
  // Firmware load held until acknowledged
  task automatic fw(input logic [12:0] a, input logic [7:0] d);
    int n = 0;
    loc_we_i = 1'b1;
    loc_addr_i = a;
    loc_data_i = d;
    do begin
      @(negedge clock_i);
      n++;
    end while (loc_ack_o !== 1'b1 && n < 8);
    loc_we_i = 1'b0;
    if (loc_ack_o !== 1'b1) begin
      err_count++;
      print_verdict();
    end
  endtask : fw
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({page_o, bank_o}, 16'h0000);
    chk({lane_base_o, 7'h00, rsp_valid_o}, 16'h0000);
  endtask : t_reset
  task automatic t_lower_and_page();
    acc(1'b1, 8'h05, 8'hA5, 1'b0, 8'h00);
    fw({6'd2, 7'h00}, 8'h3C);
    acc(1'b1, PAGE_SEL_ADDR, 8'h01, 1'b0, 8'h00);
    acc(1'b0, 8'h80, 8'h00, 1'b0, 8'h3C);
    chk({8'h00, page_o}, 16'h0001);
    acc(1'b0, 8'h05, 8'h00, 1'b0, 8'hA5);
  endtask : t_lower_and_page
  task automatic t_banks();
    fw({6'd20, 7'h05}, 8'h77);
    fw({6'd5, 7'h7F}, 8'h5A);
    acc(1'b1, PAGE_SEL_ADDR, 8'h10, 1'b0, 8'h00);
    acc(1'b1, BANK_SEL_ADDR, 8'h01, 1'b0, 8'h00);
    acc(1'b0, 8'h85, 8'h00, 1'b0, 8'h77);
    chk({bank_o, lane_base_o}, 16'h0108);
    acc(1'b1, BANK_SEL_ADDR, 8'h00, 1'b0, 8'h00);
    acc(1'b1, PAGE_SEL_ADDR, 8'h11, 1'b0, 8'h00);
    acc(1'b0, 8'hFF, 8'h00, 1'b0, 8'h5A);
    acc(1'b0, PAGE_SEL_ADDR, 8'h00, 1'b0, 8'h11);
  endtask : t_banks
  task automatic t_absent();
    acc(1'b1, BANK_SEL_ADDR, 8'h02, 1'b0, 8'h00);
    acc(1'b0, 8'h80, 8'h00, 1'b1, 8'h00);
    acc(1'b1, PAGE_SEL_ADDR, 8'h20, 1'b0, 8'h00);
    acc(1'b1, 8'h90, 8'hAA, 1'b1, 8'h00);
    acc(1'b0, 8'h90, 8'h00, 1'b1, 8'h00);
  endtask : t_absent
  // Select and use in consecutive cycles
  task automatic t_back_to_back();
    fw({6'd3, 7'h00}, 8'hC3);
    fw({6'd1, 7'h01}, 8'h1E);
    i_pmm_host_model.send(1'b1, PAGE_SEL_ADDR, 8'h02);
    i_pmm_host_model.send(1'b0, 8'h80, 8'h00);
    i_pmm_host_model.send(1'b1, PAGE_SEL_ADDR, 8'h00);
    i_pmm_host_model.send(1'b0, 8'h81, 8'h00);
    i_pmm_host_model.idle();
    expect_rsp(1'b0, 8'h00);
    expect_rsp(1'b0, 8'hC3);
    expect_rsp(1'b0, 8'h00);
    expect_rsp(1'b0, 8'h1E);
  endtask : t_back_to_back
  // Reset in mid-run, with a non-zero bank and lane base standing
  task automatic t_reset_again();
    repeat (2) @(negedge clock_i);
    rst_i = 1'b1;
    @(negedge clock_i);
    rst_i = 1'b0;
    t_reset();
  endtask : t_reset_again
  // Enable low: a select write is not taken and no answer comes
  task automatic t_freeze();
    ce_i = 1'b0;
    i_pmm_host_model.send(1'b1, PAGE_SEL_ADDR, 8'h02);
    i_pmm_host_model.idle();
    repeat (2) @(negedge clock_i);
    ce_i = 1'b1;
    repeat (3) @(negedge clock_i);
    chk({page_o, 8'(rq.size())}, 16'h0000);
  endtask : t_freeze
  initial begin
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    t_reset();
    t_lower_and_page();
    t_banks();
    t_absent();
    t_back_to_back();
    t_reset_again();
    t_freeze();
    print_verdict();
  end
endmodule : pmm_map_tb_top
`default_nettype wire
